// ==== dis_pkg.sv ====
// Purpose: shared constants for the converter interrupt-enable and sync-busy block
// Assumes: apb slave with 32-bit data, one register per aligned word
// Notes: register indices are word indices, byte address is four times the index
package dis_pkg;
	// ************************************************************
	// register indices and byte addresses
	// ************************************************************
	localparam logic [7:0] IDX_MAIN_CONTROL = 8'h00; // converter enable control
	localparam logic [7:0] IDX_IRQ_EN_CLR = 8'h04; // clear view of the enables
	localparam logic [7:0] IDX_IRQ_EN_SET = 8'h05; // set view of the enables
	localparam logic [7:0] IDX_IRQ_FLAGS = 8'h06; // sticky event flags, read clears
	localparam logic [7:0] IDX_SYNC_BUSY = 8'h07; // synchronisation busy flags
	localparam logic [7:0] IDX_SAMPLE_DATA = 8'h08; // data register
	localparam logic [7:0] IDX_SAMPLE_BUFFER = 8'h09; // data buffer register
	localparam int ADDR_W = 12; // apb address width
	localparam int IDX_LSB = 2; // word index starts above the byte bits

	// ************************************************************
	// field positions and reset values
	// ************************************************************
	localparam int BIT_UNDERRUN = 0; // underrun enable and flag
	localparam int BIT_EMPTY = 1; // buffer-empty enable and flag
	localparam int BIT_CTRL_ENABLE = 1; // converter enable in main control
	localparam int BUSY_ENABLE = 1; // busy bit for the enable write
	localparam int BUSY_DATA = 2; // busy bit for the data write
	localparam int BUSY_BUFFER = 3; // busy bit for the buffer write
	localparam int NUM_BUSY = 3; // tracked write targets
	localparam int BUSY_BASE = 1; // first busy bit position
	localparam int IRQ_W = 2; // number of interrupt sources
	localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 2'h0; // enables reset value
	localparam logic [31:0] RD_ZERO = 32'h0000_0000; // reserved bits and unmapped reads
	localparam int SYNC_CYCLES_DEF = 4; // cycles to cross into the converter domain
	localparam int SAMPLE_W_DEF = 16; // converter sample width
endpackage

// ==== dis_sync_track.sv ====
// Purpose: tracks one synchronised write from request to completion
// Assumes: start is a one-cycle pulse, never given while busy
// Notes: models the crossing latency into the converter clock as a fixed count
`timescale 1ns/1ps
module dis_sync_track import dis_pkg::*; #(
	parameter int SYNC_CYCLES = SYNC_CYCLES_DEF
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_start,
	output logic o_busy,
	output logic o_done
);
	localparam int CNT_W = $clog2(SYNC_CYCLES + 1); // counter width
	localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(SYNC_CYCLES); // reload value
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1); // last count
	localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0); // idle count

	logic [CNT_W-1:0] cnt_reg; // cycles left in the crossing
	logic [CNT_W-1:0] cnt_next;
	logic done_reg; // completion pulse
	logic done_next;

	// ************************************************************
	// countdown: busy while the count is not zero
	// ************************************************************
	always_comb begin
		cnt_next = cnt_reg;
		if (i_start) begin
			cnt_next = CNT_LOAD; // a fresh write restarts the crossing
		end else if (cnt_reg != CNT_ZERO) begin
			cnt_next = cnt_reg - CNT_ONE;
		end
		// done stands in the last busy cycle, so the core copy lands on the edge where busy falls
		done_next = (cnt_next == CNT_ONE);
	end

	// registers only
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cnt_reg <= CNT_ZERO;
			done_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			done_reg <= done_next;
		end
	end

	assign o_busy = (cnt_reg != CNT_ZERO);
	assign o_done = done_reg;
endmodule

// ==== dis_top.sv ====
// Purpose: interrupt enables, event flags and sync-busy status of a d/a converter
// Assumes: apb master on I_SYS_CLK, events are one-cycle pulses on the same clock
// Notes: writes to a target still synchronising are refused with pslverr
`timescale 1ns/1ps
module dis_top import dis_pkg::*; #(
	parameter int SYNC_CYCLES = SYNC_CYCLES_DEF,
	parameter int SAMPLE_W = SAMPLE_W_DEF
) (
	input wire logic I_SYS_CLK,
	input wire logic I_SRST,
	input wire logic [ADDR_W-1:0] i_PADDR,
	input wire logic i_PSEL,
	input wire logic i_PENABLE,
	input wire logic i_PWRITE,
	input wire logic [31:0] i_PWDATA,
	output logic [31:0] o_PRDATA,
	output logic o_PREADY,
	output logic o_PSLVERR,
	input wire logic i_BUF_EMPTY_EVT,
	input wire logic i_UNDERRUN_EVT,
	output logic o_IRQ,
	output logic o_CONV_ENABLE,
	output logic [SAMPLE_W-1:0] o_CONV_DATA,
	output logic [SAMPLE_W-1:0] o_CONV_BUFFER
);
	// ************************************************************
	// declarations
	// ************************************************************
	logic [7:0] idx; // word index of the access
	logic setup; // setup phase of a transfer
	logic access; // completing access phase
	logic wr_fire; // accepted write takes effect
	logic rd_fire; // read completes
	logic [IRQ_W-1:0] en_reg; // shared interrupt enables
	logic [IRQ_W-1:0] en_next;
	logic [IRQ_W-1:0] flag_reg; // sticky event flags
	logic [IRQ_W-1:0] flag_next;
	logic [IRQ_W-1:0] evt; // this cycle's events
	logic ctrl_en_reg; // bus-side converter enable
	logic ctrl_en_next;
	logic [SAMPLE_W-1:0] data_reg; // bus-side data register
	logic [SAMPLE_W-1:0] data_next;
	logic [SAMPLE_W-1:0] buf_reg; // bus-side buffer register
	logic [SAMPLE_W-1:0] buf_next;
	logic core_en_reg; // converter-side enable
	logic core_en_next;
	logic [SAMPLE_W-1:0] core_data_reg; // converter-side data
	logic [SAMPLE_W-1:0] core_data_next;
	logic [SAMPLE_W-1:0] core_buf_reg; // converter-side buffer
	logic [SAMPLE_W-1:0] core_buf_next;
	logic [31:0] rdata_reg; // read data captured in setup
	logic [31:0] rdata_next;
	logic err_reg; // error decided in setup
	logic err_next;
	logic [31:0] rd_mux; // read data selection
	logic mapped; // index hits a register
	logic [NUM_BUSY-1:0] start; // write starts a crossing
	logic [NUM_BUSY-1:0] busy; // crossing in progress
	logic [NUM_BUSY-1:0] done; // crossing finished
	logic [NUM_BUSY-1:0] hit; // access targets a synchronised register
	logic [31:0] busy_word; // busy flags at their bit positions

	// ************************************************************
	// apb decode
	// ************************************************************
	assign idx = i_PADDR[IDX_LSB +: 8];
	assign setup = i_PSEL & ~i_PENABLE;
	assign o_PREADY = i_PSEL & i_PENABLE; // zero wait states
	assign access = o_PREADY;
	assign wr_fire = access & i_PWRITE & ~err_reg;
	assign rd_fire = access & ~i_PWRITE & ~err_reg;
	assign o_PSLVERR = access & err_reg;
	assign o_PRDATA = rdata_reg;

	// which synchronised register an access points at
	assign hit[BUSY_ENABLE - BUSY_BASE] = (idx == IDX_MAIN_CONTROL);
	assign hit[BUSY_DATA - BUSY_BASE] = (idx == IDX_SAMPLE_DATA);
	assign hit[BUSY_BUFFER - BUSY_BASE] = (idx == IDX_SAMPLE_BUFFER);

	// ************************************************************
	// one crossing tracker per synchronised register
	// ************************************************************
	genvar g;
	generate
		for (g = 0; g < NUM_BUSY; g++) begin : g_sync
			assign start[g] = wr_fire & hit[g];
			assign busy_word[BUSY_BASE + g] = busy[g];
			dis_sync_track #(
				.SYNC_CYCLES(SYNC_CYCLES)
			) u_track (
				.i_clk(I_SYS_CLK),
				.i_srst(I_SRST),
				.i_start(start[g]),
				.o_busy(busy[g]),
				.o_done(done[g])
			);
		end
	endgenerate
	assign busy_word[BUSY_BASE-1:0] = '0; // unused low bit reads zero
	assign busy_word[31:BUSY_BASE+NUM_BUSY] = '0; // reserved bits read zero

	// ************************************************************
	// read mux and error decision, taken in the setup cycle
	// ************************************************************
	always_comb begin
		rd_mux = RD_ZERO;
		mapped = 1'b1;
		unique case (idx)
			IDX_MAIN_CONTROL: rd_mux[BIT_CTRL_ENABLE] = ctrl_en_reg;
			IDX_IRQ_EN_CLR: rd_mux[IRQ_W-1:0] = en_reg;
			IDX_IRQ_EN_SET: rd_mux[IRQ_W-1:0] = en_reg;
			IDX_IRQ_FLAGS: rd_mux[IRQ_W-1:0] = flag_reg;
			IDX_SYNC_BUSY: rd_mux = busy_word;
			IDX_SAMPLE_DATA: rd_mux[SAMPLE_W-1:0] = data_reg;
			IDX_SAMPLE_BUFFER: rd_mux[SAMPLE_W-1:0] = buf_reg;
			default: mapped = 1'b0; // unmapped reads zero with an error
		endcase
	end

	// a write to a target still crossing would be lost halfway, so it is refused
	always_comb begin
		rdata_next = rdata_reg;
		err_next = err_reg;
		if (setup) begin
			rdata_next = i_PWRITE ? RD_ZERO : rd_mux;
			err_next = ~mapped | (i_PWRITE & |(hit & busy));
		end
	end

	// registers for the setup-cycle decision
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			rdata_reg <= RD_ZERO;
			err_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			err_reg <= err_next;
		end
	end

	// ************************************************************
	// interrupt enables: set view and clear view on one state
	// ************************************************************
	// next enables from set-view and clear-view writes
	always_comb begin
		en_next = en_reg;
		if (wr_fire && idx == IDX_IRQ_EN_SET) begin
			en_next = en_reg | i_PWDATA[IRQ_W-1:0];
		end else if (wr_fire && idx == IDX_IRQ_EN_CLR) begin
			en_next = en_reg & ~i_PWDATA[IRQ_W-1:0];
		end
	end

	// one enable state behind both views
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			en_reg <= IRQ_EN_RESET;
		end else begin
			en_reg <= en_next;
		end
	end

	// ************************************************************
	// sticky flags: a read clears only the bits it returned
	// ************************************************************
	assign evt[BIT_EMPTY] = i_BUF_EMPTY_EVT;
	assign evt[BIT_UNDERRUN] = i_UNDERRUN_EVT;

	// read-clear first, then events, so an event on the clear edge is kept
	always_comb begin
		flag_next = flag_reg;
		if (rd_fire && idx == IDX_IRQ_FLAGS) begin
			flag_next = flag_reg & ~rdata_reg[IRQ_W-1:0];
		end
		flag_next = flag_next | evt; // a new event beats the clear
	end

	// sticky flag registers
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			flag_reg <= '0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign o_IRQ = |(flag_reg & en_reg);

	// ************************************************************
	// bus-side copies of the synchronised registers
	// ************************************************************
	always_comb begin
		ctrl_en_next = ctrl_en_reg;
		data_next = data_reg;
		buf_next = buf_reg;
		if (wr_fire) begin
			if (idx == IDX_MAIN_CONTROL) begin
				ctrl_en_next = i_PWDATA[BIT_CTRL_ENABLE];
			end
			if (idx == IDX_SAMPLE_DATA) begin
				data_next = i_PWDATA[SAMPLE_W-1:0];
			end
			if (idx == IDX_SAMPLE_BUFFER) begin
				buf_next = i_PWDATA[SAMPLE_W-1:0];
			end
		end
	end

	// ************************************************************
	// converter-side values, taken when each crossing completes
	// ************************************************************
	always_comb begin
		core_en_next = core_en_reg;
		core_data_next = core_data_reg;
		core_buf_next = core_buf_reg;
		if (done[BUSY_ENABLE - BUSY_BASE]) begin
			core_en_next = ctrl_en_reg;
		end
		if (done[BUSY_DATA - BUSY_BASE]) begin
			core_data_next = data_reg;
		end
		if (done[BUSY_BUFFER - BUSY_BASE]) begin
			core_buf_next = buf_reg;
		end
	end

	// bus-side and converter-side copies registered together
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			ctrl_en_reg <= 1'b0;
			data_reg <= '0;
			buf_reg <= '0;
			core_en_reg <= 1'b0;
			core_data_reg <= '0;
			core_buf_reg <= '0;
		end else begin
			ctrl_en_reg <= ctrl_en_next;
			data_reg <= data_next;
			buf_reg <= buf_next;
			core_en_reg <= core_en_next;
			core_data_reg <= core_data_next;
			core_buf_reg <= core_buf_next;
		end
	end

	assign o_CONV_ENABLE = core_en_reg;
	assign o_CONV_DATA = core_data_reg;
	assign o_CONV_BUFFER = core_buf_reg;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (I_SRST);

	chk_clr_empty: assert property (
		wr_fire && idx == IDX_IRQ_EN_CLR && i_PWDATA[BIT_EMPTY] |=> !en_reg[BIT_EMPTY]
	) else $error("empty enable not cleared");

	chk_clr_underrun: assert property (
		wr_fire && idx == IDX_IRQ_EN_CLR && i_PWDATA[BIT_UNDERRUN] |=> !en_reg[BIT_UNDERRUN]
	) else $error("underrun enable not cleared");

	chk_zero_write_keeps: assert property (
		wr_fire && (idx == IDX_IRQ_EN_SET || idx == IDX_IRQ_EN_CLR) && i_PWDATA[IRQ_W-1:0] == '0
		|=> en_reg == $past(en_reg)
	) else $error("zero write changed enables");

	chk_set_empty: assert property (
		wr_fire && idx == IDX_IRQ_EN_SET && i_PWDATA[BIT_EMPTY] |=> en_reg[BIT_EMPTY]
	) else $error("empty enable not set");

	chk_set_underrun: assert property (
		wr_fire && idx == IDX_IRQ_EN_SET && i_PWDATA[BIT_UNDERRUN] |=> en_reg[BIT_UNDERRUN]
	) else $error("underrun enable not set");

	chk_views_shared: assert property (
		setup && !i_PWRITE && (idx == IDX_IRQ_EN_SET || idx == IDX_IRQ_EN_CLR)
		|=> o_PRDATA == {30'h0, $past(en_reg)}
	) else $error("enable views disagree");

	chk_buffer_busy: assert property (
		start[BUSY_BUFFER - BUSY_BASE] |=> busy_word[BUSY_BUFFER] ##[1:SYNC_CYCLES] !busy_word[BUSY_BUFFER]
	) else $error("buffer busy wrong");

	chk_data_busy: assert property (
		start[BUSY_DATA - BUSY_BASE] |=> busy_word[BUSY_DATA] ##[1:SYNC_CYCLES] !busy_word[BUSY_DATA]
	) else $error("data busy wrong");

	chk_enable_busy: assert property (
		start[BUSY_ENABLE - BUSY_BASE] |=> busy_word[BUSY_ENABLE] ##[1:SYNC_CYCLES]
		(!busy_word[BUSY_ENABLE] && o_CONV_ENABLE == ctrl_en_reg)
	) else $error("enable busy wrong");

	chk_busy_ends: assert property (
		$fell(busy_word[BUSY_DATA]) |-> o_CONV_DATA == data_reg
	) else $error("busy fell before data arrived");

	chk_irq_gate: assert property (
		o_IRQ |-> |(flag_reg & en_reg)
	) else $error("irq without enabled flag");

	// an enabled event must show on the request line one edge later
	chk_irq_raise: assert property (
		(i_BUF_EMPTY_EVT && en_next[BIT_EMPTY]) || (i_UNDERRUN_EVT && en_next[BIT_UNDERRUN]) |=> o_IRQ
	) else $error("enabled event raised no irq");

	chk_flag_read_clear: assert property (
		rd_fire && idx == IDX_IRQ_FLAGS && evt == '0 |=> (flag_reg & rdata_reg[IRQ_W-1:0]) == '0
	) else $error("flag read left returned bits set");

	// refusals are decided in the setup cycle
	chk_busy_refuse: assert property (
		setup && i_PWRITE && (hit & busy) != '0 |=> err_reg
	) else $error("write to syncing target not refused");

	chk_unmapped_err: assert property (
		setup && !mapped |=> err_reg
	) else $error("unmapped access not refused");

	// converter side changes only at the end of a crossing
	chk_enable_hold: assert property (
		!done[BUSY_ENABLE - BUSY_BASE] |=> $stable(o_CONV_ENABLE)
	) else $error("converter enable moved outside a crossing");

	chk_data_hold: assert property (
		!done[BUSY_DATA - BUSY_BASE] |=> $stable(o_CONV_DATA)
	) else $error("converter data moved outside a crossing");

	chk_buffer_hold: assert property (
		!done[BUSY_BUFFER - BUSY_BASE] |=> $stable(o_CONV_BUFFER)
	) else $error("converter buffer moved outside a crossing");
endmodule

// ==== tb_top.sv ====
// Purpose: self-checking bench for the converter interrupt-enable and sync-busy block
// Assumes: apb master driven at the rising edge, zero-wait-state slave, sync window of SYNC_CYCLES
// Notes: SYNC_CYCLES is raised to 8 so a refused write lands well inside the busy window
`timescale 1ns/1ps
module tb_top;
	import dis_pkg::*;
	// ************************************************************
	// clock, reset and design signals
	// ************************************************************
	localparam int SYNC_N = 8; // crossing length given to the design
	logic clk = 1'b0; // system clock, 25 ns period
	logic srst = 1'b1; // synchronous reset, active high
	logic [ADDR_W-1:0] paddr = '0; // apb byte address
	logic psel = 1'b0; // apb select
	logic penable = 1'b0; // apb access phase
	logic pwrite = 1'b0; // apb direction
	logic [31:0] pwdata = '0; // apb write data
	logic [31:0] prdata; // apb read data
	logic pready; // apb ready
	logic pslverr; // apb error
	logic evt_empty = 1'b0; // buffer-empty event pulse
	logic evt_under = 1'b0; // underrun event pulse
	logic irq; // interrupt request level
	logic conv_en; // converter-side enable
	logic [15:0] conv_data; // converter-side data
	logic [15:0] conv_buf; // converter-side buffer
	int failures = 0; // mismatches seen
	int n_compared = 0; // comparisons made

	dis_top #(.SYNC_CYCLES(SYNC_N), .SAMPLE_W(16)) dis_top_inst (
		.I_SYS_CLK(clk), .I_SRST(srst), .i_PADDR(paddr), .i_PSEL(psel), .i_PENABLE(penable),
		.i_PWRITE(pwrite), .i_PWDATA(pwdata), .o_PRDATA(prdata), .o_PREADY(pready),
		.o_PSLVERR(pslverr), .i_BUF_EMPTY_EVT(evt_empty), .i_UNDERRUN_EVT(evt_under),
		.o_IRQ(irq), .o_CONV_ENABLE(conv_en), .o_CONV_DATA(conv_data), .o_CONV_BUFFER(conv_buf)
	);

	// free-running clock
	initial begin
		forever #12.5 clk = ~clk;
	end

	// ************************************************************
	// shared tasks
	// ************************************************************
	// single comparison point, four-state so an unknown never matches
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one apb transfer; an edge passes first so psel is never assigned twice in one step
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		// wait for ready at a rising edge, bounded so a hang is reported
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			failures++;
			$display("Error pready expected 1 seen %b", pready);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// write and compare the error response
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic exp_err);
		logic [31:0] rd;
		logic err;
		apb(1'b1, a, d, rd, err);
		check("write error", {31'h0, err}, {31'h0, exp_err});
	endtask

	// read and compare both data and error response
	task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] exp,
			input logic exp_err);
		logic [31:0] rd;
		logic err;
		apb(1'b0, a, 32'h0, rd, err);
		check(nm, rd, exp);
		check("read error", {31'h0, err}, {31'h0, exp_err});
	endtask

	// let the edge's updates land, then look at the settled level
	task automatic settle();
		@(posedge clk);
		#1;
	endtask

	// one-cycle event pulse on source i (0 underrun, 1 empty)
	task automatic pulse(input int i);
		@(posedge clk);
		if (i == BIT_EMPTY) evt_empty <= 1'b1;
		else evt_under <= 1'b1;
		@(posedge clk);
		evt_empty <= 1'b0;
		evt_under <= 1'b0;
		settle();
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	// reset values, unmapped access, set and clear views against one enable state
	task automatic test_views();
		rd_chk("set view reset", 12'h014, 32'h0, 1'b0);
		rd_chk("clear view reset", 12'h010, 32'h0, 1'b0);
		rd_chk("busy reset", 12'h01c, 32'h0, 1'b0);
		rd_chk("unmapped read", 12'h03c, 32'h0, 1'b1);
		wr(12'h014, 32'h0000_0003, 1'b0);
		rd_chk("clear view after set", 12'h010, 32'h3, 1'b0);
		wr(12'h014, 32'h0000_0000, 1'b0);
		wr(12'h010, 32'h0000_0000, 1'b0);
		rd_chk("zero writes", 12'h014, 32'h3, 1'b0);
		wr(12'h010, 32'h0000_0002, 1'b0);
		rd_chk("empty cleared", 12'h014, 32'h1, 1'b0);
		wr(12'h010, 32'h0000_0001, 1'b0);
		rd_chk("underrun cleared", 12'h010, 32'h0, 1'b0);
		wr(12'h014, 32'h0000_0001, 1'b0);
		rd_chk("underrun set alone", 12'h010, 32'h1, 1'b0);
	endtask

	// interrupt only while flag and matching enable are both set
	task automatic test_irq();
		for (int i = 0; i < IRQ_W; i++) begin
			wr(12'h010, 32'h0000_0003, 1'b0);
			pulse(i);
			check("irq masked", {31'h0, irq}, 32'h0);
			wr(12'h014, 32'h1 << i, 1'b0);
			settle();
			check("irq enabled", {31'h0, irq}, 32'h1);
			wr(12'h010, 32'h1 << i, 1'b0);
			settle();
			check("irq disabled", {31'h0, irq}, 32'h0);
			wr(12'h014, 32'h1 << i, 1'b0);
			rd_chk("flags", 12'h018, 32'h1 << i, 1'b0);
			settle();
			check("irq after flag read", {31'h0, irq}, 32'h0);
			pulse(i);
			check("irq live event", {31'h0, irq}, 32'h1);
			rd_chk("flags again", 12'h018, 32'h1 << i, 1'b0);
		end
	endtask

	// each synchronised write raises its busy bit, refuses a second write, then completes
	task automatic test_busy();
		logic [ADDR_W-1:0] addr [3] = '{12'h000, 12'h020, 12'h024};
		logic [31:0] val [3] = '{32'h0000_0002, 32'h0000_1234, 32'h0000_beef};
		logic [31:0] conv;
		for (int i = 0; i < NUM_BUSY; i++) begin
			wr(addr[i], val[i], 1'b0);
			rd_chk("busy during sync", 12'h01c, 32'h1 << (i + BUSY_BASE), 1'b0);
			wr(addr[i], 32'h0000_0000, 1'b1);
			repeat (SYNC_N + 4) @(posedge clk);
			rd_chk("busy after sync", 12'h01c, 32'h0, 1'b0);
			#1;
			conv = (i == 0) ? {31'h0, conv_en} : (i == 1) ? {16'h0, conv_data} : {16'h0, conv_buf};
			check("converter side", conv, (i == 0) ? 32'h1 : val[i]);
		end
	endtask

	// ************************************************************
	// verdict, watchdog and main sequence
	// ************************************************************
	task automatic finish_test();
		$display("Comparisons %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// the whole sequence needs well under 2000 cycles; this span cuts a hang short
	initial begin
		#(25 * 20000);
		failures++;
		finish_test();
	end

	initial begin
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		test_views();
		test_irq();
		test_busy();
		settle();
		finish_test();
	end
endmodule
